// >>> hdl/nfc_defines.vh
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// register offsets, one aligned word each
`define NFC_A_CTRL 8'h00
`define NFC_A_ADDR 8'h04
`define NFC_A_LEN 8'h08
`define NFC_A_CHG 8'h0C
`define NFC_A_UNLK 8'h10
`define NFC_A_PINS 8'h14
`define NFC_A_BPTR 8'h18
`define NFC_A_BDATA 8'h1C
`define NFC_A_STAT 8'h20

// field positions
`define NFC_CTRL_START 3
`define NFC_CHG_EN 31
`define NFC_UNLK_INV 31
`define NFC_PINS_WP 0
`define NFC_PINS_LOCK 1
`define NFC_PINS_RST 2'h2

// operation codes written to the control register
`define NFC_OP_CPROG 3'h1
`define NFC_OP_PROG 3'h2
`define NFC_OP_ERASE 3'h3
`define NFC_OP_RMOVE 3'h4
`define NFC_OP_PMOVE 3'h5
`define NFC_OP_UNLK 3'h6
`define NFC_OP_STAT 3'h7

// command bytes on the flash bus
`define NFC_C_READ 8'h00
`define NFC_C_PCONF 8'h10
`define NFC_C_CACHE 8'h15
`define NFC_C_LOLIM 8'h23
`define NFC_C_HILIM 8'h24
`define NFC_C_MVCONF 8'h35
`define NFC_C_ESET 8'h60
`define NFC_C_STATUS 8'h70
`define NFC_C_PSET 8'h80
`define NFC_C_COLCHG 8'h85
`define NFC_C_ECONF 8'hD0

// status byte bits
`define NFC_SB_FAIL 0
`define NFC_SB_PRIOR_ERR 1
`define NFC_SB_ARRAY_IDLE 5
`define NFC_SB_RDY 6
`define NFC_SB_WP 7

// timing
`define NFC_CLK_NS 10
`define NFC_T_WB_NS 100
`define NFC_T_WB_CYC ((`NFC_T_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_DIV 2
`define NFC_BUF_AW 12

`endif

// >>> hdl/nfc_buf.v
`timescale 1ns/100ps
// page buffer: one write port, two registered read ports
module nfc_buf #(
	parameter DW = 8,
	parameter AW = 12
) (
	// clock
	input wire clk,
	// write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	// read ports
	input wire [AW-1:0] raddr_a,
	output reg [DW-1:0] rdata_a,
	input wire [AW-1:0] raddr_b,
	output reg [DW-1:0] rdata_b
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on purpose so the array maps onto block memory
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule // nfc_buf

// >>> hdl/nfc_top.v
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`include "nfc_defines.vh"
// Behaviour
// - cached program is setup, address cycles, data from column, cached confirm.
// - column-change command may come anytime in data input; data resumes there.
// - prior cache error flag shown; ending host polls array idle, checks both flags.
// - erase is setup, two row cycles, confirm; die then busy for erase time.
// - erase outcome shows in fail flag once both ready bits set.
// - internal move only between blocks of equal parity.
// - between move steps only status and column changes; reset spoils cache.
// - host reads moved data, corrects it, re-enters it when programming.
// - after write protect pulses low, blocks stay locked until fresh unlock.
// - lower boundary block is always below upper boundary block.
// - unlock byte with lower bound, second byte with upper bound, invert in PA0.
module nfc_top #(
	parameter DIV = `NFC_DIV,
	parameter AW = `NFC_BUF_AW
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	// flash bus
	output reg nand_ce_n,
	output reg nand_cle,
	output reg nand_ale,
	output reg nand_we_n,
	output reg nand_re_n,
	output wire nand_wp_n,
	output wire nand_lock,
	output reg [7:0] nand_io_o,
	output reg nand_io_oe,
	input wire [7:0] nand_io_i,
	input wire nand_rb_n
);
	localparam [3:0] S_IDLE = 4'd0, S_PRE70 = 4'd1, S_PRERD = 4'd2, S_CMD1 = 4'd3;
	localparam [3:0] S_ADR = 4'd4, S_DIN = 4'd5, S_CC85 = 4'd6, S_CCADR = 4'd7;
	localparam [3:0] S_CMD2 = 4'd8, S_ADR2 = 4'd9, S_WB = 4'd10, S_POST70 = 4'd11;
	localparam [3:0] S_POSTRD = 4'd12, S_RDM00 = 4'd13, S_DOUT = 4'd14;
	localparam [31:0] DIV_W = DIV - 1;
	localparam [31:0] WB_W = `NFC_T_WB_CYC - 1;
	// both counts fit in eight bits; the cut is deliberate
	localparam [7:0] DIV_M1 = DIV_W[7:0];
	localparam [7:0] WB_M1 = WB_W[7:0];

	// first command byte of each operation
	function [7:0] cmd1_of(input [2:0] op);
		case (op)
			`NFC_OP_ERASE: cmd1_of = `NFC_C_ESET;
			`NFC_OP_RMOVE: cmd1_of = `NFC_C_READ;
			`NFC_OP_PMOVE: cmd1_of = `NFC_C_COLCHG; // cache kept
			`NFC_OP_UNLK: cmd1_of = `NFC_C_LOLIM; // lock-tight is never sent
			default: cmd1_of = `NFC_C_PSET; // setup wipes the die's cache
		endcase
	endfunction

	// closing command byte of each operation
	function [7:0] cmd2_of(input [2:0] op);
		case (op)
			`NFC_OP_CPROG: cmd2_of = `NFC_C_CACHE;
			`NFC_OP_ERASE: cmd2_of = `NFC_C_ECONF;
			`NFC_OP_RMOVE: cmd2_of = `NFC_C_MVCONF; // page read, other confirm
			`NFC_OP_UNLK: cmd2_of = `NFC_C_HILIM;
			default: cmd2_of = `NFC_C_PCONF;
		endcase
	endfunction

	// address byte i: two column bytes then two row bytes
	function [7:0] adr_byte(input [1:0] i, input [11:0] col, input [15:0] row);
		case (i)
			2'd0: adr_byte = col[7:0];
			2'd1: adr_byte = {4'h0, col[11:8]};
			2'd2: adr_byte = row[7:0];
			default: adr_byte = row[15:8];
		endcase
	endfunction

	// die state good enough: cached steps need only die ready
	function ready_ok(input [2:0] op, input post, input [7:0] s);
		if (op == `NFC_OP_CPROG || (!post && op == `NFC_OP_PROG)) begin
			ready_ok = s[`NFC_SB_RDY];
		end else begin
			ready_ok = s[`NFC_SB_RDY] & s[`NFC_SB_ARRAY_IDLE];
		end
	endfunction

	reg [2:0] op_r;
	reg [11:0] col_r;
	reg [15:0] row_r;
	reg [AW-1:0] len_r;
	reg [AW-1:0] chg_at_r;
	reg [11:0] chg_col_r;
	reg chg_en_r;
	reg [9:0] lo_r;
	reg [9:0] hi_r;
	reg inv_r;
	reg [1:0] pins_r;
	reg [AW-1:0] ptr_r;
	reg [7:0] stat_r;
	reg err_r, prot_r, unl_ok_r, mv_pend_r, mv_par_r, done_r;
	reg [3:0] st_r;
	reg [1:0] ph_r;
	reg [1:0] ac_r;
	reg [7:0] div_r;
	reg [7:0] wb_r;
	reg [AW-1:0] cnt_r;
	reg chg_done_r;
	reg ap_wr_r, ap_rd_buf_r;
	reg [7:0] ap_adr_r;
	reg [31:0] hrdata_r;
	reg [31:0] rd_nxt;
	reg [7:0] byte_nxt;
	wire [7:0] buf_a, buf_b;

	// ahb address phase and register writes in the data phase
	wire ap = hsel & hready & htrans[1];
	wire wr_ctrl = ap_wr_r && ap_adr_r == `NFC_A_CTRL;
	wire idle = st_r == S_IDLE;
	wire start = wr_ctrl & hwdata[`NFC_CTRL_START] & idle;
	wire [2:0] new_op = hwdata[2:0];
	wire wr_bdata = ap_wr_r && ap_adr_r == `NFC_A_BDATA && idle;
	wire rd_bdata = ap && !hwrite && haddr[7:0] == `NFC_A_BDATA;
	wire refuse = new_op == 3'h0 ||
		(new_op == `NFC_OP_PMOVE && (!mv_pend_r || row_r[6] != mv_par_r)) ||
		(new_op == `NFC_OP_UNLK && (lo_r >= hi_r || !pins_r[`NFC_PINS_LOCK]));

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = ap_rd_buf_r ? {24'h00_0000, buf_b} : hrdata_r;
	assign nand_wp_n = pins_r[`NFC_PINS_WP];
	assign nand_lock = pins_r[`NFC_PINS_LOCK];

	// engine timing: every flash bus cycle is four ticks of the divider
	wire tick = div_r == DIV_M1;
	wire is_rd = st_r == S_PRERD || st_r == S_POSTRD || st_r == S_DOUT;
	wire is_bus = st_r != S_IDLE && st_r != S_WB;
	wire is_cmd = st_r == S_PRE70 || st_r == S_CMD1 || st_r == S_CC85 ||
		st_r == S_CMD2 || st_r == S_POST70 || st_r == S_RDM00;
	wire is_adr = st_r == S_ADR || st_r == S_CCADR || st_r == S_ADR2;
	wire cyc_end = is_bus && tick && ph_r == 2'd3;
	wire smp = is_rd && tick && ph_r == 2'd1;
	wire [AW-1:0] cnt_inc = cnt_r + 1'b1;
	wire two_adr = op_r == `NFC_OP_ERASE || op_r == `NFC_OP_UNLK;
	wire [15:0] adr_row = (op_r == `NFC_OP_UNLK) ? {lo_r, 6'h00} : row_r;
	wire [15:0] hi_row = {hi_r, 5'h00, inv_r}; // invert flag in lowest page bit

	nfc_buf #(.DW(8), .AW(AW)) u_buf (
		.clk(hclk),
		.we((st_r == S_DOUT) ? smp : wr_bdata),
		.waddr((st_r == S_DOUT) ? cnt_r : ptr_r),
		.wdata((st_r == S_DOUT) ? nand_io_i : hwdata[7:0]),
		.raddr_a(cnt_r),
		.rdata_a(buf_a),
		.raddr_b(ptr_r),
		.rdata_b(buf_b)
	);

	// byte driven on the flash bus in the current cycle
	always @* begin
		case (st_r)
			S_CMD1: byte_nxt = cmd1_of(op_r);
			S_ADR: byte_nxt = adr_byte(ac_r + (two_adr ? 2'd2 : 2'd0), col_r, adr_row);
			S_DIN: byte_nxt = buf_a;
			S_CC85: byte_nxt = `NFC_C_COLCHG;
			S_CCADR: byte_nxt = adr_byte(ac_r, chg_col_r, row_r);
			S_CMD2: byte_nxt = cmd2_of(op_r);
			S_ADR2: byte_nxt = adr_byte(ac_r + 2'd2, 12'h000, hi_row);
			S_RDM00: byte_nxt = `NFC_C_READ;
			default: byte_nxt = `NFC_C_STATUS;
		endcase
	end

	// register read mux, captured in the address phase
	always @* begin
		if (haddr[7:0] == `NFC_A_CTRL) begin
			rd_nxt = {28'h000_0000, ~idle, op_r};
		end else if (haddr[7:0] == `NFC_A_ADDR) begin
			rd_nxt = {row_r, 4'h0, col_r};
		end else if (haddr[7:0] == `NFC_A_LEN) begin
			rd_nxt = {{(32-AW){1'b0}}, len_r};
		end else if (haddr[7:0] == `NFC_A_CHG) begin
			rd_nxt = {chg_en_r, 3'h0, chg_col_r, {(16-AW){1'b0}}, chg_at_r};
		end else if (haddr[7:0] == `NFC_A_UNLK) begin
			rd_nxt = {inv_r, 5'h00, hi_r, 6'h00, lo_r};
		end else if (haddr[7:0] == `NFC_A_PINS) begin
			rd_nxt = {30'h0000_0000, pins_r};
		end else if (haddr[7:0] == `NFC_A_BPTR) begin
			rd_nxt = {{(32-AW){1'b0}}, ptr_r};
		end else if (haddr[7:0] == `NFC_A_STAT) begin
			rd_nxt = {17'h0_0000, done_r, nand_rb_n, mv_pend_r, unl_ok_r, prot_r, err_r,
				~idle, stat_r};
		end else begin
			rd_nxt = 32'h0000_0000;
		end
	end

	// bus slave and software registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r <= 1'b0;
			ap_rd_buf_r <= 1'b0;
			ap_adr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			op_r <= 3'h0;
			col_r <= 12'h000;
			row_r <= 16'h0000;
			len_r <= {AW{1'b0}};
			chg_at_r <= {AW{1'b0}};
			chg_col_r <= 12'h000;
			chg_en_r <= 1'b0;
			lo_r <= 10'h000;
			hi_r <= 10'h000;
			inv_r <= 1'b0;
			pins_r <= `NFC_PINS_RST;
			ptr_r <= {AW{1'b0}};
		end else begin
			ap_wr_r <= ap & hwrite;
			ap_rd_buf_r <= rd_bdata;
			ap_adr_r <= haddr[7:0];
			if (ap && !hwrite) begin
				hrdata_r <= rd_nxt;
			end
			// setup registers are frozen while an operation runs
			if (ap_wr_r && idle) begin
				if (ap_adr_r == `NFC_A_CTRL) begin
					op_r <= new_op;
				end else if (ap_adr_r == `NFC_A_ADDR) begin
					col_r <= hwdata[11:0];
					row_r <= hwdata[31:16];
				end else if (ap_adr_r == `NFC_A_LEN) begin
					len_r <= hwdata[AW-1:0];
				end else if (ap_adr_r == `NFC_A_CHG) begin
					chg_at_r <= hwdata[AW-1:0];
					chg_col_r <= hwdata[27:16];
					chg_en_r <= hwdata[`NFC_CHG_EN];
				end else if (ap_adr_r == `NFC_A_UNLK) begin
					lo_r <= hwdata[9:0];
					hi_r <= hwdata[25:16];
					inv_r <= hwdata[`NFC_UNLK_INV];
				end
			end
			if (ap_wr_r && ap_adr_r == `NFC_A_PINS) begin
				pins_r <= hwdata[1:0];
			end
			// buffer pointer steps after each data access
			if (ap_wr_r && ap_adr_r == `NFC_A_BPTR && idle) begin
				ptr_r <= hwdata[AW-1:0];
			end else begin
				ptr_r <= ptr_r + {{(AW-1){1'b0}}, wr_bdata} + {{(AW-1){1'b0}}, rd_bdata};
			end
		end
	end

	// operation sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= S_IDLE;
			ph_r <= 2'd0;
			ac_r <= 2'd0;
			div_r <= 8'h00;
			wb_r <= 8'h00;
			cnt_r <= {AW{1'b0}};
			chg_done_r <= 1'b0;
			stat_r <= 8'h00;
			err_r <= 1'b0;
			prot_r <= 1'b0;
			done_r <= 1'b0;
			unl_ok_r <= 1'b0; // all blocks start locked
			mv_pend_r <= 1'b0;
			mv_par_r <= 1'b0;
		end else begin
			div_r <= (tick || !is_bus) ? 8'h00 : div_r + 8'h01;
			if (is_bus && tick) begin
				ph_r <= ph_r + 2'd1;
			end
			if (smp && st_r != S_DOUT) begin
				stat_r <= nand_io_i;
			end
			// a write-protect pulse drops any unlocked range
			if (!pins_r[`NFC_PINS_WP]) begin
				unl_ok_r <= 1'b0;
			end
			if (start) begin
				err_r <= refuse;
				done_r <= 1'b0;
				prot_r <= 1'b0;
				chg_done_r <= 1'b0;
				if (!refuse) begin
					st_r <= S_PRE70;
					if (new_op != `NFC_OP_STAT) begin
						mv_pend_r <= 1'b0; // anything else spoils the moved page
					end
				end
			end else if (st_r == S_WB) begin
				// let the die pull its ready bits down before polling
				wb_r <= wb_r + 8'h01;
				if (wb_r == WB_M1) begin
					st_r <= S_POST70;
				end
			end else if (cyc_end) begin
				ac_r <= 2'd0;
				case (st_r)
					S_PRE70: st_r <= S_PRERD;
					S_PRERD: begin
						if (op_r == `NFC_OP_STAT) begin
							st_r <= S_IDLE;
							done_r <= 1'b1;
						end else begin
							st_r <= ready_ok(op_r, 1'b0, stat_r) ? S_CMD1 : S_PRE70;
						end
					end
					S_CMD1: st_r <= S_ADR;
					S_ADR: begin
						ac_r <= ac_r + 2'd1;
						cnt_r <= {AW{1'b0}};
						if (ac_r == (two_adr ? 2'd1 : 2'd3)) begin
							if (two_adr || op_r == `NFC_OP_RMOVE || len_r == {AW{1'b0}}) begin
								st_r <= S_CMD2;
							end else begin
								st_r <= S_DIN; // data starts at the given column
							end
						end
					end
					S_DIN: begin
						cnt_r <= cnt_inc;
						if (cnt_inc == len_r) begin
							st_r <= S_CMD2;
						end else if (chg_en_r && !chg_done_r && cnt_inc == chg_at_r) begin
							st_r <= S_CC85;
							chg_done_r <= 1'b1;
						end
					end
					S_CC85: st_r <= S_CCADR;
					S_CCADR: begin
						ac_r <= ac_r + 2'd1;
						if (ac_r == 2'd1) begin
							st_r <= S_DIN;
						end
					end
					S_CMD2: begin
						wb_r <= 8'h00;
						st_r <= (op_r == `NFC_OP_UNLK) ? S_ADR2 : S_WB;
					end
					S_ADR2: begin
						ac_r <= ac_r + 2'd1;
						if (ac_r == 2'd1) begin
							st_r <= S_IDLE;
							done_r <= 1'b1;
							unl_ok_r <= 1'b1; // new range replaces the old
						end
					end
					S_POST70: st_r <= S_POSTRD;
					S_POSTRD: begin
						// finished: fail flags now valid in the status byte
						if (ready_ok(op_r, 1'b1, stat_r)) begin
							prot_r <= ~stat_r[`NFC_SB_WP]; // locked target
							if (op_r == `NFC_OP_RMOVE) begin
								mv_pend_r <= 1'b1;
								mv_par_r <= row_r[6];
							end
							if (op_r == `NFC_OP_RMOVE && len_r != {AW{1'b0}}) begin
								st_r <= S_RDM00; // pull the page out for checking
							end else begin
								st_r <= S_IDLE;
								done_r <= 1'b1;
							end
						end else begin
							st_r <= S_POST70;
						end
					end
					S_RDM00: begin
						cnt_r <= {AW{1'b0}};
						st_r <= S_DOUT;
					end
					default: begin
						cnt_r <= cnt_inc;
						if (cnt_inc == len_r) begin
							st_r <= S_IDLE;
							done_r <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// flash pins come straight from flops
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nand_ce_n <= 1'b1;
			nand_cle <= 1'b0;
			nand_ale <= 1'b0;
			nand_we_n <= 1'b1;
			nand_re_n <= 1'b1;
			nand_io_o <= 8'h00;
			nand_io_oe <= 1'b0;
		end else begin
			nand_ce_n <= idle;
			nand_cle <= is_cmd;
			nand_ale <= is_adr;
			nand_we_n <= !(is_bus && !is_rd && ph_r == 2'd1);
			nand_re_n <= !(is_rd && ph_r == 2'd1);
			nand_io_o <= byte_nxt;
			nand_io_oe <= is_bus && !is_rd;
		end
	end
endmodule // nfc_top

// >>> tb/nfc_flash_model.sv
`timescale 1ns/100ps
// behavioural die: small array, one cache page, one unlock range
module nfc_flash_model #(
	parameter T_CB = 20,
	parameter T_PR = 60,
	parameter T_ER = 80,
	parameter T_LB = 6,
	parameter BAD = 10'h014
) (
	// host clock, times the busy spans
	input wire clk,
	// bus from the host
	input wire ce_n,
	input wire cle,
	input wire ale,
	input wire we_n,
	input wire re_n,
	input wire wp_n,
	input wire lock,
	input wire [7:0] din,
	// answers
	output wire [7:0] dout,
	output wire rb_n
);
	logic [7:0] mem [0:16383];
	logic [7:0] cache [0:255];
	logic [7:0] cmd = 8'h00, last = 8'h00;
	logic [31:0] ad;
	logic [15:0] rw;
	logic [11:0] cp;
	logic [9:0] lo, hi;
	logic we_q = 1, re_q = 1, en = 0, uv = 0, inv = 0, prot = 0, fail = 0, prior_err = 0;
	int cb = 0, ab = 0, n = 0;
	wire [9:0] blk = rw[15:6];
	wire rdy = cb == 0;
	wire arr_idle = ab == 0;
	wire [7:0] sb = {~prot, rdy, arr_idle, 3'b000, prior_err, fail};
	wire free = !en || uv && (inv ? blk < lo || blk > hi : blk >= lo && blk <= hi);
	// a released bus shows the inverse of the last byte, so stale data cannot pass
	assign dout = (!re_n && !ce_n) ? (cmd == 8'h70 ? sb : cache[cp[7:0]]) : ~last;
	assign rb_n = rdy;
	// the strap counts only at power-on; taken a few clocks in, once reset has set the pin
	initial begin : strap
		repeat (2) @(posedge clk);
		en = lock;
	end
	// strobes are taken at their rising edge, while cle, ale and data still stand
	always @(posedge clk) begin : step
		logic [15:0] r;
		r = {din, ad[31:24]};
		we_q <= we_n;
		re_q <= re_n;
		if (cb > 0)
			cb <= cb - 1;
		if (ab > 0)
			ab <= ab - 1;
		if (!re_n && !ce_n)
			last <= dout;
		if (!re_q && re_n && cmd != 8'h70)
			cp <= cp + 1;
		if (!we_q && we_n && !ce_n) begin
			last <= din;
			if (ale) begin
				ad <= {din, ad[31:8]};
				n <= n + 1;
				if (n == 1)
					cp <= r[11:0];
				if (n == 3 || n == 1 && (cmd == 8'h60 || cmd[7:4] == 4'h2))
					rw <= r;
				if (n == 1 && cmd == 8'h24 && en) begin
					hi <= r[15:6];
					inv <= r[0];
					uv <= 1'b1;
				end
			end else if (!cle) begin
				cache[cp[7:0]] <= din;
				cp <= cp + 1;
			end else begin
				cmd <= din;
				n <= 0;
				case (din)
				8'h80:
					for (int i = 0; i < 256; i++)
						cache[i] <= 8'hFF;
				8'h24: lo <= rw[15:6];
				8'h10, 8'h15, 8'hD0: if (din != 8'hD0 || rdy && arr_idle) begin
					prot <= !free;
					fail <= free && blk == BAD;
					cb <= !free ? T_LB : din == 8'h15 ? T_CB : din == 8'h10 ? T_PR : T_ER;
					ab <= !free ? T_LB : din == 8'h15 ? T_CB + T_PR : din == 8'h10 ? T_PR : T_ER;
					if (din == 8'h15)
						prior_err <= fail;
					if (din != 8'hD0 && free)
						for (int i = 0; i < 256; i++)
							mem[{rw[9:6], rw[1:0], 8'(i)}] <= cache[i];
				end
				8'h35: begin
					cb <= T_CB;
					ab <= T_CB;
					for (int i = 0; i < 256; i++)
						cache[i] <= mem[{rw[9:6], rw[1:0], 8'(i)}];
				end
				default: n <= 0;
				endcase
			end
		end
		if (!wp_n)
			uv <= 1'b0;
	end
endmodule // nfc_flash_model

// >>> tb/nfc_chk_assertions.sv
`timescale 1ns/100ps
// pin-level checks of the controller
module nfc_chk #(
	parameter DIV = 2
) (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bus answer
	input wire hreadyout,
	input wire hresp,
	// flash bus
	input wire nand_ce_n,
	input wire nand_cle,
	input wire nand_ale,
	input wire nand_we_n,
	input wire nand_re_n,
	input wire [7:0] nand_io_o,
	input wire nand_io_oe
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_bus_no_wait: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	a_idle_at_release: assert property ($rose(hresetn) |-> nand_ce_n && nand_we_n && !nand_io_oe)
		else $error("flash bus busy after reset");
	a_latch_exclusive: assert property (!(nand_cle && nand_ale))
		else $error("command and address latch together");
	a_strobe_exclusive: assert property (nand_we_n || nand_re_n)
		else $error("write and read strobe together");
	a_strobe_selected: assert property (!nand_we_n || !nand_re_n |-> !nand_ce_n)
		else $error("strobe without chip enable");
	// strobe width written for DIV of 2: one tick is two clocks
	a_we_pulse_width: assert property ($fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n)
		else $error("write strobe width wrong");
	a_write_held: assert property (!nand_we_n |-> nand_io_oe && $stable(nand_io_o)
		&& $stable(nand_cle) && $stable(nand_ale))
		else $error("bus moved under write strobe");
	a_read_released: assert property (!nand_re_n |-> !nand_io_oe)
		else $error("host drives bus during read");
	a_setup_then_addr: assert property (
		$fell(nand_we_n) && nand_cle && nand_io_o == 8'h80 |-> ##[1:16] ($fell(nand_we_n) && nand_ale))
		else $error("no address after program setup");
	a_erase_then_row: assert property (
		$fell(nand_we_n) && nand_cle && nand_io_o == 8'h60 |-> ##[1:16] ($fell(nand_we_n) && nand_ale))
		else $error("no row after erase setup");
	a_unlock_then_bound: assert property (
		$fell(nand_we_n) && nand_cle && nand_io_o == 8'h23 |-> ##[1:16] ($fell(nand_we_n) && nand_ale))
		else $error("no bound after unlock");
endmodule // nfc_chk

bind nfc_top nfc_chk #(.DIV(DIV)) i_nfc_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale),
	.nand_we_n(nand_we_n), .nand_re_n(nand_re_n), .nand_io_o(nand_io_o), .nand_io_oe(nand_io_oe));

// >>> tb/nfc_top_bench.sv
`timescale 1ns/100ps
`include "nfc_defines.vh"
// register-level scenarios against the behavioural die
module nfc_top_bench;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, s;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'h3C};
	wire hready, hreadyout, hresp, ce_n, cle, ale, we_n, re_n, wp_n, lck, oe, rb_n;
	wire [31:0] hrdata;
	wire [7:0] io_o, io_i, io;
	int num_errors = 0;
	int n_checks = 0;
	assign hready = hreadyout;
	assign io = oe ? io_o : io_i;
	nfc_top #(.DIV(2), .AW(12)) i_nfc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nand_ce_n(ce_n),
		.nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_wp_n(wp_n),
		.nand_lock(lck), .nand_io_o(io_o), .nand_io_oe(oe), .nand_io_i(io), .nand_rb_n(rb_n));
	nfc_flash_model i_nfc_flash_model (.clk(hclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .lock(lck), .din(io), .dout(io_i), .rb_n(rb_n));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// one single word transfer; read data lands in s
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= 32'(a);
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		s = hrdata;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// start one operation, then poll until busy drops
	task automatic op(input logic [2:0] c, input logic [31:0] a, input logic [11:0] n);
		xfer(1, `NFC_A_ADDR, a);
		xfer(1, `NFC_A_LEN, 32'(n));
		xfer(1, `NFC_A_CTRL, {28'h000_0000, 1'b1, c});
		do xfer(0, `NFC_A_STAT, 0); while (s[8] !== 1'b0);
	endtask
	// the first two bytes that a read-for-move left in the buffer
	task automatic rd2(input logic [15:0] e);
		xfer(1, `NFC_A_BPTR, 0);
		xfer(0, `NFC_A_BDATA, 0);
		chk(s[7:0], e[15:8]);
		xfer(0, `NFC_A_BDATA, 0);
		chk(s[7:0], e[7:0]);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// the scenarios need far fewer than 40k cycles
	initial begin
		#400_000;
		num_errors++;
		finish_test();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(0, `NFC_A_PINS, 0);
		chk(s, 32'h0000_0002);
		xfer(0, 8'h40, 0);
		chk(s, 0);
		xfer(1, `NFC_A_PINS, 3);
		xfer(1, `NFC_A_BPTR, 0);
		foreach (pat[i])
			xfer(1, `NFC_A_BDATA, 32'(pat[i]));
		// everything starts locked; then open blocks 2 to 9
		op(`NFC_OP_PROG, 32'h0100_0000, 3);
		chk({s[10], s[7]}, 2'b10);
		xfer(1, `NFC_A_UNLK, 32'h0009_0002);
		op(`NFC_OP_UNLK, 0, 0);
		chk(s[11:9], 3'b100);
		// two cached programs, the second with a column change
		op(`NFC_OP_CPROG, 32'h0100_0000, 3);
		xfer(1, `NFC_A_CHG, 32'h8008_0001);
		op(`NFC_OP_CPROG, 32'h0101_0000, 3);
		chk(s[10:0], 11'h0C0);
		xfer(1, `NFC_A_CHG, 0);
		// internal move from block 4 to block 8, then a parity clash
		op(`NFC_OP_RMOVE, 32'h0101_0000, 2);
		chk(s[14:12], 3'b111);
		rd2(16'hA5FF);
		op(`NFC_OP_PMOVE, 32'h0201_0000, 0);
		chk(s[10:0], 11'h0E0);
		op(`NFC_OP_RMOVE, 32'h0201_0008, 2);
		rd2(16'h5A3C);
		op(`NFC_OP_PMOVE, 32'h0140_0000, 0);
		chk(s[9], 1);
		// erase outside the range, then with the range inverted
		op(`NFC_OP_ERASE, 32'h0300_0000, 0);
		chk(s[10], 1);
		xfer(1, `NFC_A_UNLK, 32'h8009_0002);
		op(`NFC_OP_UNLK, 0, 0);
		op(`NFC_OP_ERASE, 32'h0300_0000, 0);
		chk(s[10:0], 11'h0E0);
		op(`NFC_OP_ERASE, 32'h0500_0000, 0);
		chk(s[7:0], 8'hE1);
		// refused starts
		xfer(1, `NFC_A_UNLK, 32'h0002_0009);
		op(`NFC_OP_UNLK, 0, 0);
		chk(s[9], 1);
		op(3'h0, 0, 0);
		chk(s[9], 1);
		// a write-protect pulse relocks until a fresh unlock
		xfer(1, `NFC_A_PINS, 2);
		xfer(1, `NFC_A_PINS, 3);
		op(`NFC_OP_ERASE, 32'h0300_0000, 0);
		chk(s[11:10], 2'b01);
		op(`NFC_OP_STAT, 0, 0);
		chk(s[7:0], 8'h60);
		finish_test();
	end
endmodule // nfc_top_bench
